// ===== design/pav_regs_map.svh
// Register map, field positions and reset values
`ifndef PAV_REGS_MAP_SVH
`define PAV_REGS_MAP_SVH

// ----------------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------------
`define PAV_ADDR_ADVERT 5'h04
`define PAV_ADDR_PARTNER 5'h05
`define PAV_ADDR_EXPANSION 5'h06
`define PAV_ADDR_VENDOR 5'h10

// ----------------------------------------------------------------------
// Reset values and fixed fields
// ----------------------------------------------------------------------
`define PAV_ADVERT_RESET 16'h01E1
`define PAV_ADVERT_WMASK 16'h21E0
`define PAV_SELECTOR 5'h01
`define PAV_PARTNER_RESET 16'h0000
`define PAV_EXPANSION_RESET 16'h0000
`define PAV_VENDOR_RESET 16'h0140
`define PAV_VENDOR_FIXED 16'h0140
`define PAV_VENDOR_WMASK 16'hDC33

// ----------------------------------------------------------------------
// Vendor register bit positions
// ----------------------------------------------------------------------
`define PAV_BIT_REPEATER 15
`define PAV_BIT_IRQ_POL 14
`define PAV_BIT_TX_HIGH_Z 12
`define PAV_BIT_HB_INHIBIT 11
`define PAV_BIT_NAT_LOOP 10
`define PAV_BIT_AUTO_POLARITY_DISABLE_DIS 5
`define PAV_BIT_RX_INVERT 4
`define PAV_BIT_CODE_BYPASS 1
`define PAV_BIT_RXCLK_GATE 0

`endif

// ===== design/pav_pkg.sv
// Types shared by the management register block
package pav_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [15:0] wdata;
    } pav_mgmt_req_type;

    typedef struct packed {
        logic valid;
        logic [15:0] rdata;
    } pav_mgmt_rsp_type;

    typedef struct packed {
        logic speed_10m;
        logic speed_100m;
        logic autoneg_on;
        logic loopback;
    } pav_mode_type;
endpackage

// ===== design/pav_regs.sv
// Advertisement selector, partner/expansion capture and vendor config
`timescale 1ns/100ps
`include "pav_regs_map.svh"
module pav_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire pav_pkg::pav_mgmt_req_type mgmt_req,
    output pav_pkg::pav_mgmt_rsp_type mgmt_rsp,
    input wire pav_pkg::pav_mode_type mode,
    input wire logic partner_load,
    input wire logic [15:0] partner_data,
    input wire logic expansion_load,
    input wire logic [15:0] expansion_data,
    input wire logic rx_active,
    input wire logic tx_active,
    input wire logic tx_frame_done,
    input wire logic polarity_reversed,
    input wire logic phy_event,
    input wire logic tx_bit,
    output logic tx_pair_pos_out,
    output logic tx_pair_pos_oe_n,
    output logic tx_pair_neg_out,
    output logic tx_pair_neg_oe_n,
    output logic carrier_sense,
    output logic collision_pulse,
    output logic full_duplex_allowed,
    output logic phy_irq,
    output logic rx_invert,
    output logic natural_loopback_10m,
    output logic coding_bypass_active,
    output logic rx_clock_stop
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [15:0] advert_reg, advert_next;
    logic [15:0] partner_reg, partner_next;
    logic [15:0] expansion_reg, expansion_next;
    logic [15:0] vendor_reg, vendor_next;
    logic auto_inv_reg, auto_inv_next;
    pav_pkg::pav_mgmt_rsp_type rsp_reg, rsp_next;
    logic carrier_reg, carrier_next;
    logic coll_reg, coll_next;
    logic tx_pos_reg, tx_pos_next;
    logic tx_neg_reg, tx_neg_next;

    logic repeater_enable;
    logic tx_high_z_enable;
    logic heartbeat_test_inhibit;
    logic auto_polarity_disable;
    logic heartbeat_active;
    logic wr_vendor;

    // Applies a write mask so read-only bits keep their value
    function automatic logic [15:0] masked_write(
        input logic [15:0] old_value,
        input logic [15:0] new_value,
        input logic [15:0] mask
    );
        masked_write = (old_value & ~mask) | (new_value & mask);
    endfunction

    // Read view of the vendor register
    function automatic logic [15:0] vendor_view(
        input logic [15:0] stored,
        input logic auto_inv
    );
        logic [15:0] v;
        v = (stored & `PAV_VENDOR_WMASK) | `PAV_VENDOR_FIXED;
        if (!stored[`PAV_BIT_AUTO_POLARITY_DISABLE_DIS]) begin
            v[`PAV_BIT_RX_INVERT] = auto_inv;
        end
        vendor_view = v;
    endfunction

    assign repeater_enable = vendor_reg[`PAV_BIT_REPEATER];
    assign tx_high_z_enable = vendor_reg[`PAV_BIT_TX_HIGH_Z];
    assign heartbeat_test_inhibit = vendor_reg[`PAV_BIT_HB_INHIBIT];
    assign auto_polarity_disable = vendor_reg[`PAV_BIT_AUTO_POLARITY_DISABLE_DIS];
    assign heartbeat_active = mode.speed_10m && !heartbeat_test_inhibit;
    assign wr_vendor = mgmt_req.wr && (mgmt_req.addr == `PAV_ADDR_VENDOR);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    always_comb begin
        advert_next = advert_reg;
        partner_next = partner_reg;
        expansion_next = expansion_reg;
        vendor_next = vendor_reg;
        if (mgmt_req.wr && (mgmt_req.addr == `PAV_ADDR_ADVERT)) begin
            // Selector bits are outside the mask, so writes never land
            advert_next = masked_write(advert_reg, mgmt_req.wdata,
                `PAV_ADVERT_WMASK);
        end
        advert_next[4:0] = `PAV_SELECTOR;
        if (partner_load) begin
            partner_next = partner_data;
        end
        if (expansion_load) begin
            expansion_next = expansion_data;
        end
        if (wr_vendor) begin
            vendor_next = masked_write(vendor_reg, mgmt_req.wdata,
                `PAV_VENDOR_WMASK);
            // Invert bit only accepts a value while auto-polarity is off
            if (!mgmt_req.wdata[`PAV_BIT_AUTO_POLARITY_DISABLE_DIS]) begin
                vendor_next[`PAV_BIT_RX_INVERT] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            advert_reg <= `PAV_ADVERT_RESET;
            partner_reg <= `PAV_PARTNER_RESET;
            expansion_reg <= `PAV_EXPANSION_RESET;
            vendor_reg <= `PAV_VENDOR_RESET;
        end else begin
            advert_reg <= advert_next;
            partner_reg <= partner_next;
            expansion_reg <= expansion_next;
            vendor_reg <= vendor_next;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        rsp_next.valid = mgmt_req.rd;
        rsp_next.rdata = 16'h0000;
        if (mgmt_req.rd) begin
            case (mgmt_req.addr)
                `PAV_ADDR_ADVERT: begin
                    rsp_next.rdata = advert_reg;
                end
                `PAV_ADDR_PARTNER: begin
                    rsp_next.rdata = partner_reg;
                end
                `PAV_ADDR_EXPANSION: begin
                    rsp_next.rdata = expansion_reg;
                end
                `PAV_ADDR_VENDOR: begin
                    rsp_next.rdata = vendor_view(vendor_reg, auto_inv_reg);
                end
                default: begin
                    rsp_next.rdata = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= rsp_next;
        end
    end

    assign mgmt_rsp = rsp_reg;

    // ------------------------------------------------------------------
    // Line side
    // ------------------------------------------------------------------
    always_comb begin
        // Detector result is only tracked in 10BASE-T with auto enabled
        auto_inv_next = auto_inv_reg;
        if (auto_polarity_disable) begin
            auto_inv_next = 1'b0;
        end else if (mode.speed_10m) begin
            auto_inv_next = polarity_reversed;
        end
        // Repeater carrier ignores own transmit activity
        carrier_next = repeater_enable ? rx_active
                                       : (rx_active || tx_active);
        coll_next = tx_frame_done && heartbeat_active;
        tx_pos_next = tx_bit;
        tx_neg_next = !tx_bit;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_inv_reg <= 1'b0;
            carrier_reg <= 1'b0;
            coll_reg <= 1'b0;
            tx_pos_reg <= 1'b0;
            tx_neg_reg <= 1'b0;
        end else begin
            auto_inv_reg <= auto_inv_next;
            carrier_reg <= carrier_next;
            coll_reg <= coll_next;
            tx_pos_reg <= tx_pos_next;
            tx_neg_reg <= tx_neg_next;
        end
    end

    assign carrier_sense = carrier_reg;
    assign collision_pulse = coll_reg;
    assign full_duplex_allowed = !repeater_enable;
    assign tx_pair_pos_out = tx_pos_reg;
    assign tx_pair_neg_out = tx_neg_reg;
    // Receive pins have no enable here, so they stay live in high-Z mode
    assign tx_pair_pos_oe_n = tx_high_z_enable;
    assign tx_pair_neg_oe_n = tx_high_z_enable;
    // Low polarity is the safe default for the internal interrupt path
    assign phy_irq = vendor_reg[`PAV_BIT_IRQ_POL] ? phy_event
                                                  : !phy_event;
    assign rx_invert = auto_polarity_disable
        ? vendor_reg[`PAV_BIT_RX_INVERT] : auto_inv_reg;
    assign natural_loopback_10m = vendor_reg[`PAV_BIT_NAT_LOOP];
    // Bypass is meaningless outside forced 100BASE-TX, so it is gated
    assign coding_bypass_active = vendor_reg[`PAV_BIT_CODE_BYPASS]
        && mode.speed_100m && !mode.autoneg_on;
    assign rx_clock_stop = vendor_reg[`PAV_BIT_RXCLK_GATE]
        && mode.speed_100m && !mode.loopback && !rx_active;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_selector_fixed: assert property (
        mgmt_req.rd && mgmt_req.addr == `PAV_ADDR_ADVERT
        |=> mgmt_rsp.valid && mgmt_rsp.rdata[4:0] == 5'h01)
        else $error("selector not 0x01");
    a_partner_capture: assert property (
        partner_load |=> partner_reg == $past(partner_data))
        else $error("partner ability not captured");
    a_expansion_capture: assert property (
        expansion_load ##1 (mgmt_req.rd && !expansion_load
            && mgmt_req.addr == `PAV_ADDR_EXPANSION)
        |=> mgmt_rsp.rdata == $past(expansion_data, 2))
        else $error("expansion readback wrong");
    a_vendor_fixed: assert property (
        mgmt_req.rd && mgmt_req.addr == `PAV_ADDR_VENDOR
        |=> mgmt_rsp.rdata[9:6] == 4'h5 && mgmt_rsp.rdata[13] == 1'b0)
        else $error("vendor reserved field wrong");
    a_repeater_duplex: assert property (
        repeater_enable && tx_active && !rx_active
        |-> !full_duplex_allowed ##1 !carrier_sense)
        else $error("repeater mode misbehaves");
    a_tx_float: assert property (
        wr_vendor && mgmt_req.wdata[12]
        |=> tx_pair_pos_oe_n && tx_pair_neg_oe_n)
        else $error("transmit pins still driven");
    a_heartbeat_inhibit: assert property (
        heartbeat_test_inhibit |=> !collision_pulse)
        else $error("heartbeat while inhibited");
    a_heartbeat_pulse: assert property (
        tx_frame_done && mode.speed_10m && !heartbeat_test_inhibit
        |=> collision_pulse ##1 (!collision_pulse || $past(tx_frame_done)))
        else $error("heartbeat pulse missing");
    a_irq_polarity: assert property (
        !vendor_reg[14] |-> phy_irq != phy_event)
        else $error("interrupt polarity wrong");
    a_auto_polarity: assert property (
        !auto_polarity_disable && mode.speed_10m
        ##1 !auto_polarity_disable |-> rx_invert == $past(polarity_reversed))
        else $error("auto polarity not followed");
    a_rx_gate_loop: assert property (
        mode.loopback |-> !rx_clock_stop)
        else $error("clock gated in loopback");
    a_bypass_gate: assert property (
        mode.autoneg_on |-> !coding_bypass_active)
        else $error("bypass with negotiation on");
    a_bypass_speed: assert property (
        !mode.speed_100m |-> !coding_bypass_active)
        else $error("bypass outside 100BASE-TX");
    a_selector_write: assert property (
        mgmt_req.wr |=> advert_reg[4:0] == `PAV_SELECTOR)
        else $error("selector changed by a write");
    // Read-only contents may only move on a capture strobe
    a_partner_hold: assert property (
        !partner_load |=> $stable(partner_reg))
        else $error("partner ability changed without load");
    a_expansion_hold: assert property (
        !expansion_load |=> $stable(expansion_reg))
        else $error("expansion status changed without load");
    a_repeater_write: assert property (
        wr_vendor && mgmt_req.wdata[15] |=> !full_duplex_allowed)
        else $error("full duplex still allowed in repeater mode");
    a_forced_invert: assert property (
        wr_vendor && mgmt_req.wdata[`PAV_BIT_AUTO_POLARITY_DISABLE_DIS]
        |=> rx_invert == $past(mgmt_req.wdata[`PAV_BIT_RX_INVERT]))
        else $error("forced invert not applied");
    a_invert_cleared: assert property (
        wr_vendor && !mgmt_req.wdata[`PAV_BIT_AUTO_POLARITY_DISABLE_DIS]
        |=> !vendor_reg[`PAV_BIT_RX_INVERT])
        else $error("invert stored while auto-polarity on");
    a_irq_active_high: assert property (
        vendor_reg[`PAV_BIT_IRQ_POL] |-> phy_irq == phy_event)
        else $error("active high interrupt wrong");
    a_rx_gate_busy: assert property (
        rx_active |-> !rx_clock_stop)
        else $error("clock gated while receiving");
    a_heartbeat_speed: assert property (
        tx_frame_done && !mode.speed_10m |=> !collision_pulse)
        else $error("heartbeat outside 10BASE-T");

    // Main scenarios the bench reaches, except c_vendor_write: no read directly follows a vendor write
    c_heartbeat: cover property (tx_frame_done ##1 collision_pulse);
    c_repeater_carrier: cover property (repeater_enable && rx_active
        ##1 carrier_sense);
    c_load_then_read: cover property (expansion_load ##1 mgmt_req.rd);
    c_vendor_write: cover property (wr_vendor ##1 mgmt_rsp.valid);
    c_forced_invert: cover property (auto_polarity_disable && rx_invert);
endmodule

// ===== verification/pav_host_model.sv
// Host management model: register reads, writes and read-modify-write
`timescale 1ns/100ps
module pav_host_model (
    input wire logic clk,
    output pav_pkg::pav_mgmt_req_type mgmt_req,
    input wire pav_pkg::pav_mgmt_rsp_type mgmt_rsp
);
    initial mgmt_req = '0;

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk);
        mgmt_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        mgmt_req = '0;
    endtask

    // Answer may come late; the wait is bounded so a hang still ends
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        int i;
        @(negedge clk);
        mgmt_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge clk);
        mgmt_req = '0;
        d = 16'hXXXX;
        for (i = 0; i < 4; i++) begin
            if (mgmt_rsp.valid === 1'b1) begin
                d = mgmt_rsp.rdata;
                break;
            end
            @(negedge clk);
        end
    endtask

    // Bits outside the mask go back exactly as read
    task automatic rmw(input logic [4:0] a, input logic [15:0] m,
                       input logic [15:0] v);
        logic [15:0] d;
        rd(a, d);
        wr(a, (d & ~m) | (v & m));
    endtask
endmodule

// ===== verification/pav_regs_tb.sv
// Testbench for the management register block
`timescale 1ns/100ps
module pav_regs_tb;
    logic clk, rst_n, partner_load, expansion_load, rx_active, tx_active;
    logic tx_frame_done, polarity_reversed, phy_event, tx_bit;
    logic [15:0] partner_data, expansion_data;
    logic tx_pos, tx_pos_oe_n, tx_neg, tx_neg_oe_n, carrier, col_pulse;
    logic fdx_ok, irq, rx_inv, nat_loop, bypass, clk_stop;
    pav_pkg::pav_mgmt_req_type mgmt_req;
    pav_pkg::pav_mgmt_rsp_type mgmt_rsp;
    pav_pkg::pav_mode_type mode;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;

    pav_regs u_pav_regs (.clk(clk), .rst_n(rst_n), .mgmt_req(mgmt_req),
        .mgmt_rsp(mgmt_rsp), .mode(mode), .partner_load(partner_load),
        .partner_data(partner_data), .expansion_load(expansion_load),
        .expansion_data(expansion_data), .rx_active(rx_active),
        .tx_active(tx_active), .tx_frame_done(tx_frame_done),
        .polarity_reversed(polarity_reversed), .phy_event(phy_event),
        .tx_bit(tx_bit), .tx_pair_pos_out(tx_pos),
        .tx_pair_pos_oe_n(tx_pos_oe_n), .tx_pair_neg_out(tx_neg),
        .tx_pair_neg_oe_n(tx_neg_oe_n), .carrier_sense(carrier),
        .collision_pulse(col_pulse), .full_duplex_allowed(fdx_ok),
        .phy_irq(irq), .rx_invert(rx_inv),
        .natural_loopback_10m(nat_loop),
        .coding_bypass_active(bypass), .rx_clock_stop(clk_stop));

    pav_host_model u_pav_host_model (.clk(clk), .mgmt_req(mgmt_req),
        .mgmt_rsp(mgmt_rsp));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rc(input logic [4:0] a, input logic [15:0] e);
        logic [15:0] d;
        u_pav_host_model.rd(a, d);
        check($sformatf("reg %h", a), d, e);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        u_pav_host_model.wr(a, d);
    endtask

    // One frame end; the pulse must last exactly one cycle
    task automatic frame_end(input logic exp);
        @(negedge clk);
        tx_frame_done = 1'b1;
        @(negedge clk);
        tx_frame_done = 1'b0;
        check("col_pulse", col_pulse, exp);
        @(negedge clk);
        check("col_pulse", col_pulse, 1'b0);
    endtask

    task automatic give_verdict;
        if (fail_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            give_verdict();
        end
    end

    initial begin
        rst_n = 1'b0;
        mode = '0;
        {partner_load, expansion_load, rx_active, tx_active} = 4'h0;
        {tx_frame_done, polarity_reversed, phy_event, tx_bit} = 4'h0;
        partner_data = 16'h0000;
        expansion_data = 16'h0000;
        repeat (12) @(negedge clk);
        check("tx_pos_oe_n", tx_pos_oe_n, 1'b0);
        check("irq", irq, 1'b1);
        rst_n = 1'b1;
        rc(5'h04, 16'h01E1);
        rc(5'h05, 16'h0000);
        rc(5'h06, 16'h0000);
        rc(5'h10, 16'h0140);
        rc(5'h07, 16'h0000);
        wr(5'h04, 16'hFFFF);
        rc(5'h04, 16'h21E1);
        wr(5'h04, 16'h0000);
        rc(5'h04, 16'h0001);
        @(negedge clk);
        {partner_data, expansion_data} = {16'hA5C3, 16'h3C5A};
        {partner_load, expansion_load} = 2'h3;
        // Read straight after the capture, while the strobe falls
        fork
            rc(5'h06, 16'h3C5A);
            begin
                @(negedge clk);
                {partner_load, expansion_load} = 2'h0;
            end
        join
        rc(5'h05, 16'hA5C3);
        wr(5'h05, 16'h0000);
        wr(5'h06, 16'h0000);
        rc(5'h05, 16'hA5C3);
        rc(5'h06, 16'h3C5A);
        wr(5'h10, 16'hFFFF);
        rc(5'h10, 16'hDD73);
        check("fdx_ok", fdx_ok, 1'b0);
        check("tx_pos_oe_n", tx_pos_oe_n, 1'b1);
        check("tx_neg_oe_n", tx_neg_oe_n, 1'b1);
        check("rx_inv", rx_inv, 1'b1);
        check("nat_loop", nat_loop, 1'b1);
        phy_event = 1'b1;
        #1 check("irq", irq, 1'b1);
        @(negedge clk);
        tx_active = 1'b1;
        repeat (2) @(negedge clk);
        check("carrier", carrier, 1'b0);
        rx_active = 1'b1;
        repeat (2) @(negedge clk);
        check("carrier", carrier, 1'b1);
        {rx_active, tx_active} = 2'h0;
        mode.speed_100m = 1'b1;
        #1 check("bypass", bypass, 1'b1);
        check("clk_stop", clk_stop, 1'b1);
        @(negedge clk);
        {mode.autoneg_on, mode.loopback} = 2'h3;
        #1 check("bypass", bypass, 1'b0);
        check("clk_stop", clk_stop, 1'b0);
        wr(5'h10, 16'h0000);
        rc(5'h10, 16'h0140);
        check("fdx_ok", fdx_ok, 1'b1);
        check("irq", irq, 1'b0);
        tx_bit = 1'b1;
        repeat (2) @(negedge clk);
        check("tx_pos", tx_pos, 1'b1);
        check("tx_neg", tx_neg, 1'b0);
        mode = '{speed_10m: 1'b1, speed_100m: 1'b0, autoneg_on: 1'b0,
                 loopback: 1'b0};
        frame_end(1'b1);
        u_pav_host_model.rmw(5'h10, 16'h0800, 16'h0800);
        frame_end(1'b0);
        polarity_reversed = 1'b1;
        repeat (4) @(negedge clk);
        check("rx_inv", rx_inv, 1'b1);
        rc(5'h10, 16'h0950);
        wr(5'h10, 16'h0820);
        check("rx_inv", rx_inv, 1'b0);
        give_verdict();
    end
endmodule
